//--- hw/readback_defs.svh
// register offsets, field positions and reset values of the readback request registers
// assumes: included by the package and the main module, after any header comment
`ifndef READBACK_DEFS_SVH
`define READBACK_DEFS_SVH

// offsets are word indices; byte address is four times the index
`define RB_IDX_CFG_B 12'h008
`define RB_IDX_CFG_C 12'h009
`define RB_IDX_OE 12'h00a
`define RB_IDX_MAIN 12'h00b
`define RB_IDX_PENDING 12'h040
`define RB_ADDR_W 12

`define RB_RESET_VAL 8'h00

// first configuration readback command register
`define SEL_EOT_CFG_1 7
`define SEL_EOT_CFG_0 6
`define SEL_SENSOR_CFG_1 5
`define SEL_SENSOR_CFG_0 4
`define SEL_OPERATING_CFG_0 3
`define SEL_COMMS_CFG_1 2
`define SEL_COMMS_CFG_0 1
`define SEL_IGNITION_CFG 0

// second configuration readback command register
`define SEL_INPUT_CFG_3 7
`define SEL_INPUT_CFG_0 4
`define SEL_DIRECT_DRIVE_CFG_3 3
`define SEL_DIRECT_DRIVE_CFG_0 0

// output-enable readback command register
`define SEL_SENSOR_CFG_2 4
`define SEL_OUT_ENABLE_CFG_3 3
`define SEL_OUT_ENABLE_CFG_0 0

// main readback command register
`define SEL_WINDOW_WDOG_CFG_1 6
`define SEL_ENGINE_OFF_TIMER_CFG 5
`define SEL_FUNCTIONAL_WDOG_CFG 4
`define SEL_WDOG_CFG_1 3
`define SEL_OPERATING_STATUS_1 2
`define SEL_OPERATING_STATUS_0 1
`define SEL_DIAGNOSIS_0 0

`endif

//--- hw/readback_pkg.sv
// types shared by the readback request registers and their target picker
// assumes: nothing beyond the defs header
`include "readback_defs.svh"

package readback_pkg;

  // command register groups, in the order in which their readbacks are served
  typedef enum logic [1:0] {
    GRP_CFG_B,
    GRP_CFG_C,
    GRP_OE,
    GRP_MAIN
  } rb_group_t;

  typedef logic [3:0][7:0] rb_pend_t;

endpackage

//--- hw/readback_picker.sv
// picks the next readback target: lowest group first, most significant set bit within it
// assumes: pending mask held in the caller's registers; purely combinational
`timescale 1ns/100ps
`default_nettype none

module readback_picker
  import readback_pkg::*;
(
  // pending targets
  input wire rb_pend_t pend,
  // chosen target
  output logic found,
  output rb_group_t grp,
  output logic [2:0] bit_idx
);

  wire [3:0] grp_any;
  wire [3:0][2:0] grp_msb;

  for (genvar g = 0; g < 4; g++) begin : g_grp
    logic [2:0] msb;
    always_comb begin
      msb = 3'h0;
      for (int b = 0; b < 8; b++) begin
        if (pend[g][b]) begin
          msb = 3'(b);
        end
      end
    end
    assign grp_any[g] = |pend[g];
    assign grp_msb[g] = msb;
  end

  always_comb begin
    found = |grp_any;
    grp = GRP_MAIN;
    bit_idx = 3'h0;
    for (int g = 3; g >= 0; g--) begin
      if (grp_any[g]) begin
        grp = rb_group_t'(2'(g));
        bit_idx = grp_msb[g];
      end
    end
  end

endmodule // readback_picker

`default_nettype wire

//--- hw/readback_request_registers.sv
// write-only readback request registers behind an apb slave, with a target sequencer
// assumes: apb master on clk; upstream return path takes one target per rb_valid/rb_ready
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none

`include "readback_defs.svh"

module readback_request_registers
  import readback_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // readback requests to the upstream return path
  output logic rb_valid,
  output rb_group_t rb_group,
  output logic [2:0] rb_bit,
  input wire logic rb_ready,
  // status
  output logic rb_busy
);

  typedef struct packed {
    rb_pend_t pend;
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic valid;
    rb_group_t grp;
    logic [2:0] bit_idx;
  } rb_state_t;

  rb_state_t st_ff;
  rb_state_t nxt_st;

  rb_pend_t wmask;
  rb_pend_t wr_set;
  logic hit;
  logic is_pending;
  logic is_cmd;
  rb_group_t wr_grp;
  logic setup_cyc;
  logic commit;
  logic pick_found;
  rb_group_t pick_grp;
  logic [2:0] pick_bit;

  // writable trigger bits per command register; reserved bits never latch
  always_comb begin
    wmask = '0;
    wmask[GRP_CFG_C][`SEL_INPUT_CFG_3:`SEL_INPUT_CFG_0] = 4'hf;
    wmask[GRP_CFG_C][`SEL_DIRECT_DRIVE_CFG_3:`SEL_DIRECT_DRIVE_CFG_0] = 4'hf;
    wmask[GRP_OE][`SEL_OUT_ENABLE_CFG_3:`SEL_OUT_ENABLE_CFG_0] = 4'hf;
    wmask[GRP_OE][`SEL_SENSOR_CFG_2] = 1'b1;
    wmask[GRP_CFG_B][`SEL_EOT_CFG_1] = 1'b1;
    wmask[GRP_CFG_B][`SEL_EOT_CFG_0] = 1'b1;
    wmask[GRP_CFG_B][`SEL_SENSOR_CFG_1] = 1'b1;
    wmask[GRP_CFG_B][`SEL_SENSOR_CFG_0] = 1'b1;
    wmask[GRP_CFG_B][`SEL_OPERATING_CFG_0] = 1'b1;
    wmask[GRP_CFG_B][`SEL_COMMS_CFG_1] = 1'b1;
    wmask[GRP_CFG_B][`SEL_COMMS_CFG_0] = 1'b1;
    wmask[GRP_CFG_B][`SEL_IGNITION_CFG] = 1'b1;
    wmask[GRP_MAIN][`SEL_WINDOW_WDOG_CFG_1] = 1'b1;
    wmask[GRP_MAIN][`SEL_ENGINE_OFF_TIMER_CFG] = 1'b1;
    wmask[GRP_MAIN][`SEL_FUNCTIONAL_WDOG_CFG] = 1'b1;
    wmask[GRP_MAIN][`SEL_WDOG_CFG_1] = 1'b1;
    wmask[GRP_MAIN][`SEL_OPERATING_STATUS_1] = 1'b1;
    wmask[GRP_MAIN][`SEL_OPERATING_STATUS_0] = 1'b1;
    wmask[GRP_MAIN][`SEL_DIAGNOSIS_0] = 1'b1;
  end

  // address decode; only whole aligned words are mapped
  always_comb begin
    is_cmd = 1'b1;
    is_pending = 1'b0;
    wr_grp = GRP_CFG_B;
    case (paddr)
      `RB_IDX_CFG_B << 2: begin
        wr_grp = GRP_CFG_B;
      end
      `RB_IDX_CFG_C << 2: begin
        wr_grp = GRP_CFG_C;
      end
      `RB_IDX_OE << 2: begin
        wr_grp = GRP_OE;
      end
      `RB_IDX_MAIN << 2: begin
        wr_grp = GRP_MAIN;
      end
      `RB_IDX_PENDING << 2: begin
        is_cmd = 1'b0;
        is_pending = 1'b1;
      end
      default: begin
        is_cmd = 1'b0;
      end
    endcase
    hit = is_cmd || is_pending;
  end

  readback_picker u_picker (
    .pend(st_ff.pend),
    .found(pick_found),
    .grp(pick_grp),
    .bit_idx(pick_bit)
  );

  // first access cycle decodes, second one completes: one wait state
  assign setup_cyc = psel && penable && !st_ff.ack;
  assign commit = psel && penable && st_ff.ack;

  always_comb begin
    nxt_st = st_ff;
    wr_set = '0;

    nxt_st.ack = setup_cyc;
    if (setup_cyc) begin
      // command registers are write-only and read back as zero
      nxt_st.err = !hit || (pwrite && is_pending);
      nxt_st.rdata = 32'h0000_0000;
      if (!pwrite && is_pending) begin
        nxt_st.rdata = st_ff.pend;
      end
    end

    // only ones latch; zeros and reserved positions leave the queue alone
    if (commit && pwrite && !st_ff.err && is_cmd && pstrb[0]) begin
      wr_set[wr_grp] = pwdata[7:0] & wmask[wr_grp];
    end

    // hand the current target over, then load the next one
    if (st_ff.valid && rb_ready) begin
      nxt_st.valid = 1'b0;
    end
    if (!st_ff.valid && pick_found) begin
      nxt_st.valid = 1'b1;
      nxt_st.grp = pick_grp;
      nxt_st.bit_idx = pick_bit;
      nxt_st.pend[pick_grp][pick_bit] = 1'b0;
    end

    // a trigger written in the cycle its bit is taken is queued again, not lost
    nxt_st.pend = nxt_st.pend | wr_set;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff.pend <= {4{`RB_RESET_VAL}};
      st_ff.ack <= 1'b0;
      st_ff.err <= 1'b0;
      st_ff.rdata <= 32'h0000_0000;
      st_ff.valid <= 1'b0;
      st_ff.grp <= GRP_CFG_B;
      st_ff.bit_idx <= 3'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pready = st_ff.ack;
  assign pslverr = st_ff.ack && st_ff.err;
  assign prdata = st_ff.rdata;
  assign rb_valid = st_ff.valid;
  assign rb_group = st_ff.grp;
  assign rb_bit = st_ff.bit_idx;
  assign rb_busy = st_ff.valid || pick_found;

endmodule // readback_request_registers

`default_nettype wire

//--- testbench/readback_sink.sv
// return path model: takes one readback target per handshake
// assumes: rb_valid from the registers, same clock
`timescale 1ns/100ps
`default_nettype none
module readback_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // return path
  input wire logic rb_valid,
  output logic rb_ready,
  // pacing
  input wire logic slow
);
  logic [1:0] cnt_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_ff <= 2'h0;
    else cnt_ff <= cnt_ff + {1'b0, rb_valid};
  end
  // slow mode stalls three offers in four, so targets must be held
  assign rb_ready = !slow || cnt_ff == 2'h3;
endmodule // readback_sink
`default_nettype wire

//--- testbench/readback_request_registers_props.sv
// assertions on the readback request registers
// assumes: one clock, apb with one wait state
`timescale 1ns/100ps
`default_nettype none
module readback_props
  import readback_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  // return path
  input wire logic rb_valid,
  input wire rb_group_t rb_group,
  input wire logic [2:0] rb_bit,
  input wire logic rb_ready,
  input wire logic rb_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_done; psel && penable && pready; endsequence
  sequence s_cmd; s_done ##0 pwrite && paddr inside {[12'h020:12'h02c]}; endsequence
  AST_ONE_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED: assert property (s_done ##0 paddr == 12'h030 |-> pslverr)
    else $error("unmapped access not refused");
  AST_RESET_IDLE: assert property ($fell(rst) |-> !rb_valid && !rb_busy)
    else $error("readback pending out of reset");
  AST_ZERO_WRITE: assert property (s_cmd ##0 pwdata[7:0] == 8'h00 && !rb_busy |=> !rb_busy [*2])
    else $error("zero write started a readback");
  AST_FIRST: assert property (s_cmd ##0 pwdata[4:0] != 5'h00 && pstrb[0] && !rb_busy |-> ##2 rb_valid)
    else $error("no target two cycles after write");
  AST_HOLD: assert property (rb_valid && !rb_ready |=> rb_valid && $stable(rb_group) && $stable(rb_bit))
    else $error("offered target changed before accept");
  AST_DROP: assert property (rb_valid && rb_ready |=> !rb_valid)
    else $error("rb_valid held after accept");
  AST_CMD_OKAY: assert property (s_done ##0 paddr inside {12'h020, 12'h024, 12'h028, 12'h02c}
    |-> !pslverr)
    else $error("command register access refused");
  AST_PEND_RO: assert property (s_done ##0 pwrite && paddr == 12'h100 |-> pslverr)
    else $error("write to pending status accepted");
endmodule // readback_props
bind readback_request_registers readback_props u_props (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .rb_valid(rb_valid), .rb_group(rb_group),
  .rb_bit(rb_bit), .rb_ready(rb_ready), .rb_busy(rb_busy));
`default_nettype wire

//--- testbench/test_readback_request_registers.sv
// self-checking bench for the readback request registers
// assumes: design, package, sink model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module test_readback_request_registers;
  import readback_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rb_valid, rb_ready, rb_busy, slow, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  rb_group_t rb_group;
  logic [2:0] rb_bit;
  logic [4:0] seen[$];
  logic [7:0] masks[4] = '{8'hff, 8'hff, 8'h1f, 8'h7f};
  // lowest pending group first, msb first within it
  logic [4:0] order[4] = '{5'h19, 5'h02, 5'h01, 5'h18};
  int bad_count, comparisons;
  readback_request_registers u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rb_valid(rb_valid), .rb_group(rb_group),
    .rb_bit(rb_bit), .rb_ready(rb_ready), .rb_busy(rb_busy));
  readback_sink u_sink (.clk(clk), .rst(rst), .rb_valid(rb_valid), .rb_ready(rb_ready),
    .slow(slow));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rb_valid === 1'b1 && rb_ready === 1'b1) seen.push_back({rb_group, rb_bit});
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // waits for the return path to empty; the watchdog bounds a hang
  task automatic drain;
    do @(posedge clk); while (rb_busy !== 1'b0);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    close_out;
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, slow} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h030, 32'hff);
    chk(err, 32'h1);
    apb(1'b1, 12'h100, 32'h0);
    chk(err, 32'h1);
    // host keeps reserved bits at zero; nothing beyond the mask may come back
    for (int g = 0; g < 4; g++) begin
      slow <= g[1];
      apb(1'b1, 12'h020 + 12'(4 * g), 32'h0);
      drain;
      chk(32'(seen.size()), 32'h0);
      apb(1'b1, 12'h020 + 12'(4 * g), {24'h0, masks[g]});
      chk(err, 32'h0);
      apb(1'b0, 12'h020 + 12'(4 * g), 32'h0);
      chk(rd, 32'h0);
      drain;
      for (int b = 7; b >= 0; b--) begin
        if (masks[g][b]) chk(32'(seen.pop_front()), 32'({g[1:0], b[2:0]}));
      end
      chk(32'(seen.size()), 32'h0);
      $display("test %0d done", g);
    end
    // reset in mid-run must drop every pending target
    apb(1'b1, 12'h02c, 32'h7f);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    seen.delete();
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    drain;
    chk(32'(seen.size()), 32'h0);
    $display("test reset done");
    // a write without its low byte strobe must not queue anything
    pstrb <= 4'he;
    apb(1'b1, 12'h024, 32'hff);
    pstrb <= 4'hf;
    drain;
    chk(32'(seen.size()), 32'h0);
    $display("test strobe done");
    // slow sink after reset: a later write to a lower group overtakes the rest
    apb(1'b1, 12'h02c, 32'h03);
    apb(1'b1, 12'h020, 32'h06);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0100_0002);
    drain;
    chk(32'(seen.size()), 32'h4);
    foreach (order[i]) chk(32'(seen[i]), 32'(order[i]));
    $display("test order done");
    close_out;
  end
endmodule // test_readback_request_registers
`default_nettype wire
